//--- pkg/cfg_stream_pkg.sv
// Package: constants and types shared by the configuration image streamer
package cfg_stream_pkg;
   // Image geometry
   localparam int IMAGE_BITS_DEF  = 1024;       // Default stored image length in bits
   localparam int ADDR_W_DEF      = 10;         // Default address counter width
   // Oscillator: serial clock half period in ref_clk cycles
   localparam int OSC_HALF_NS     = 20;         // Serial clock half period, ns
   localparam int REF_PERIOD_NS   = 4;          // Reference clock period, ns
   localparam int OSC_HALF_CYC    = (OSC_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int OSC_CNT_W       = 8;          // Oscillator divider width
   // FIFO
   localparam int FIFO_DEPTH_DEF  = 8;          // Words of read-ahead buffering
   localparam int FIFO_WIDTH_DEF  = 1;          // One image bit per word
   // Mode strap encoding
   localparam int MODE_W          = 2;          // Width of operating mode strap
   localparam logic [1:0] MODE_RESET_VAL = 2'h0;// Mode before first capture
   // Streamer states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,                        // Counter cleared, data floated
      ST_HALT   = 2'b01,                        // Enabled by reset release, chip select high
      ST_STREAM = 2'b10,                        // Shifting image bits out
      ST_DONE   = 2'b11                         // Image finished, cascade asserted
   } stream_state_t;
endpackage : cfg_stream_pkg

//--- rtl/bit_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             flush_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage array
   logic [PW-1:0]    wr_reg, wr_next;  // Write pointer
   logic [PW-1:0]    rd_reg, rd_next;  // Read pointer
   logic [PW:0]      cnt_reg, cnt_next;// Occupancy
   logic             push, pop;

   // Honest full and empty flags
   assign in_ready_o  = (cnt_reg != DEPTH_C);
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o  = mem_reg[rd_reg];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Pointer and count update
   always_comb begin
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      cnt_next = cnt_reg;
      if (flush_i) begin
         // Flush drops all content
         wr_next  = '0;
         rd_next  = '0;
         cnt_next = '0;
      end else begin
         if (push) wr_next = (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         if (pop)  rd_next = (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         if (push && !pop) cnt_next = cnt_reg + 1'b1;
         else if (pop && !push) cnt_next = cnt_reg - 1'b1;
      end
   end

   // Register state
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage write, no reset needed on data
   always_ff @(posedge ref_clk_i) begin
      if (push && !flush_i) mem_reg[wr_reg] <= in_data_i;
   end
endmodule : bit_fifo

//--- rtl/sync2.sv
// Two flip-flop synchroniser for a level
`timescale 1ns/1ps
module sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // Level in and out
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_reg;  // First stage, read only by the second

   // Two stage capture
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= RESET_VAL;
         sync_o   <= RESET_VAL;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule : sync2

//--- rtl/serial_config_image_streamer.sv
// Serial configuration image streamer: stores an image and shifts it to a target
// Notes for users of the block
// Every pin reaches the logic through two flip-flops, so each response
// trails its pin by three reference clock cycles.
// Chip select high in mid-stream flushes the read-ahead buffer. On
// resumption the fetch restarts at the counter, so up to a buffer's worth
// of bits is skipped: raise chip select only between images.
// The strap bits are synchronised one by one. Hold the strap steady
// around the release of the reset line, or the captured code may tear.
// The device never pulls its own reset line low. The open drain driver is
// still registered, so the pin can only ever be released or pulled.
// The serial clock runs only while streaming and rests low otherwise.
// Without the cascade option the cascade pin rests high.
// The image is a parameter, so the memory is read only; a longer image
// needs IMAGE_BITS and ADDR_W to grow together.
`timescale 1ns/1ps
module serial_config_image_streamer
   import cfg_stream_pkg::*;
#(
   parameter int  IMAGE_BITS   = cfg_stream_pkg::IMAGE_BITS_DEF,
   parameter int  ADDR_W       = cfg_stream_pkg::ADDR_W_DEF,
   parameter int  FIFO_DEPTH   = cfg_stream_pkg::FIFO_DEPTH_DEF,
   parameter bit  HAS_CASCADE  = 1'b1,
   parameter logic [IMAGE_BITS-1:0] IMAGE_INIT = '0
) (
   // Clock and reset
   input  wire logic                                ref_clk_i,
   input  wire logic                                rst_i,
   // Control pins from the target
   input  wire logic                                chip_select_n_i,
   input  wire logic                                oe_reset_i,
   output logic                                     oe_reset_o,
   output logic                                     oe_reset_oe_o,
   // Mode strap sampled at reset release
   input  wire logic [cfg_stream_pkg::MODE_W-1:0]   mode_strap_i,
   output logic [cfg_stream_pkg::MODE_W-1:0]        mode_o,
   // Serial data towards the target
   output logic                                     serial_config_clock_o,
   output logic                                     serial_data_o,
   output logic                                     serial_data_oe_o,
   output logic                                     cascade_out_n_o,
   // Boundary scan reconfigure request
   input  wire logic                                scan_reconfig_i,
   output logic                                     reconfig_request_n_o
);
   import cfg_stream_pkg::*;

   // Last image address; the counter holds here once the final bit is fetched
   localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(IMAGE_BITS - 1);
   // Divider wraps after OSC_HALF_CYC cycles, one half period of the serial clock
   localparam logic [OSC_CNT_W-1:0] OSC_HALF = OSC_CNT_W'(OSC_HALF_CYC - 1);
   // Stored image, one bit per address
   logic [IMAGE_BITS-1:0] image_mem;                   // Image contents
   assign image_mem = IMAGE_INIT;

   // Synchronised pins
   logic cs_n_s;                                       // Chip select, synchronised
   logic oe_s;                                         // Reset line level, synchronised
   logic scan_s;                                       // Scan reconfigure, synchronised

   sync2 #(.RESET_VAL(1'b1)) u_sync_cs (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (chip_select_n_i),
      .sync_o    (cs_n_s)
   );
   // sensed level of the open drain line
   sync2 #(.RESET_VAL(1'b0)) u_sync_oe (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (oe_reset_i),
      .sync_o    (oe_s)
   );
   sync2 #(.RESET_VAL(1'b0)) u_sync_scan (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (scan_reconfig_i),
      .sync_o    (scan_s)
   );
   // Mode strap, one synchroniser per bit; the strap must be steady at capture
   logic [MODE_W-1:0] strap_s;                         // Mode strap, synchronised
   for (genvar gi = 0; gi < MODE_W; gi++) begin : g_strap_sync
      sync2 #(.RESET_VAL(1'b0)) u_sync_strap (
         .ref_clk_i (ref_clk_i),
         .rst_i     (rst_i),
         .async_i   (mode_strap_i[gi]),
         .sync_o    (strap_s[gi])
      );
   end

   // State and datapath registers
   // Each group: one next-value process, one register process
   stream_state_t          state_reg, state_next;      // Sequencer state
   logic [ADDR_W-1:0]      addr_reg, addr_next;        // Address counter
   logic                   addr_done_reg, addr_done_next; // All bits fetched
   logic [OSC_CNT_W-1:0]   osc_reg, osc_next;          // Oscillator divider
   logic                   sclk_reg, sclk_next;        // Serial clock level
   logic                   data_reg, data_next;        // Bit on the data pin
   logic                   data_oe_reg, data_oe_next;  // Data pin drive
   logic                   casc_reg, casc_next;        // Cascade out, active low
   logic                   oe_prev_reg;                // Reset line last cycle
   logic [MODE_W-1:0]      mode_reg, mode_next;        // Captured mode
   logic                   req_n_reg, req_n_next;      // Reconfigure request
   logic                   od_pull_reg, od_pull_next;  // Pull the reset line
   logic                   od_level_reg, od_level_next; // Level put on the reset line

   // FIFO between memory fetch and shifter
   // Read-ahead hides fetch latency; the shifter waits on it only on each entry into streaming
   logic fill_valid, fill_ready, drain_valid, drain_ready, drain_bit, flush;
   logic fetch_bit;                                    // Bit at the counter address

   assign fetch_bit  = image_mem[addr_reg];
   // Fetch stalls when the FIFO is full, so the counter only advances on accepted bits
   assign fill_valid = (state_reg == ST_STREAM) && !addr_done_reg;
   // Flushed outside streaming, so a restart never shows stale bits
   assign flush      = (state_reg != ST_STREAM);

   bit_fifo #(.WIDTH(FIFO_WIDTH_DEF), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .flush_i     (flush),
      .in_valid_i  (fill_valid),
      .in_ready_o  (fill_ready),
      .in_data_i   (fetch_bit),
      .out_valid_o (drain_valid),
      .out_ready_i (drain_ready),
      .out_data_o  (drain_bit)
   );

   // Falling edge of the serial clock launches the next bit
   // The target samples on the rising edge, half a period after launch
   logic osc_wrap, fall_edge, rise_edge;
   assign osc_wrap    = (osc_reg == OSC_HALF);
   assign fall_edge   = (state_reg == ST_STREAM) && osc_wrap && sclk_reg;
   assign rise_edge   = (state_reg == ST_STREAM) && osc_wrap && !sclk_reg;
   // First bit is taken at once, later bits only at a falling edge
   assign drain_ready = fall_edge || (state_reg == ST_STREAM && !data_oe_reg);

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      // Pins are read only after their synchronisers
      unique case (state_reg)
         ST_IDLE: begin
            // halted after reset pulse with select high
            if (oe_s) state_next = cs_n_s ? ST_HALT : ST_STREAM;
         end
         ST_HALT: begin
            // Counter held here until select goes low
            // select low enables the counter
            if (!cs_n_s) state_next = ST_STREAM;
         end
         ST_STREAM: begin
            // finished when every bit has left the pin
            if (addr_done_reg && !drain_valid && fall_edge) state_next = ST_DONE;
            else if (cs_n_s) state_next = ST_HALT;
         end
         ST_DONE: begin
            // Image finished; only the reset line starts another
            state_next = ST_DONE;
         end
      endcase
      if (!oe_s) state_next = ST_IDLE;
   end

   // Address counter, oscillator and data pin
   // Oscillator and data pin run on the registered state and stop on the next state
   always_comb begin
      addr_next      = addr_reg;
      addr_done_next = addr_done_reg;
      osc_next       = osc_reg;
      sclk_next      = sclk_reg;
      data_next      = data_reg;
      data_oe_next   = data_oe_reg;
      casc_next      = casc_reg;
      if (state_next == ST_IDLE) begin
         addr_next      = '0;
         addr_done_next = 1'b0;
         osc_next       = '0;
         sclk_next      = 1'b0;
         data_oe_next   = 1'b0;
         casc_next      = 1'b1;
      end else if (state_reg == ST_STREAM) begin
         osc_next = osc_wrap ? '0 : osc_reg + 1'b1;
         if (rise_edge || fall_edge) sclk_next = !sclk_reg;
         // counter advances once per accepted bit
         if (fill_valid && fill_ready) begin
            // Counter parks on the last address and flags completion
            if (addr_reg == LAST_ADDR) addr_done_next = 1'b1;
            else addr_next = addr_reg + 1'b1;
         end
         if (drain_ready && drain_valid) begin
            data_next    = drain_bit;
            data_oe_next = 1'b1;
         end
         if (state_next == ST_HALT) begin
            // halted: float data, stop clock
            // Counter kept; the state change flushes the buffer
            data_oe_next = 1'b0;
            sclk_next    = 1'b0;
         end
         if (state_next == ST_DONE) begin
            // cascade only in variants that have it
            casc_next    = HAS_CASCADE ? 1'b0 : 1'b1;
            data_oe_next = 1'b0;
            sclk_next    = 1'b0;
         end
      end else begin
         // disabled: oscillator stopped, buffer off
         // Counter and held bit are kept for resumption
         osc_next     = '0;
         sclk_next    = 1'b0;
         data_oe_next = 1'b0;
      end
   end

   // Mode capture, reconfigure request and reset line driver
   always_comb begin
      mode_next = mode_reg;
      // capture mode on reset line rising
      // Strap and reset line share one sync delay, so they stay aligned
      if (oe_s && !oe_prev_reg) mode_next = strap_s;
      // request low while scan instruction active
      // release high when scan leaves the state
      // Follows the scan level, so a scan pulse that spans no reference clock edge never lowers the request
      req_n_next = !scan_s;
      // open drain: level always low, line never pulled
      // Holding the target in reset has no cause inside this block
      od_level_next = 1'b0;
      od_pull_next  = 1'b0;
   end

   // Register all state
   // Registers only: every decision is made in the processes above
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         // Reset: data floated, cascade and request released
         state_reg     <= ST_IDLE;
         addr_reg      <= '0;
         addr_done_reg <= 1'b0;
         osc_reg       <= '0;
         sclk_reg      <= 1'b0;
         data_reg      <= 1'b0;
         data_oe_reg   <= 1'b0;
         casc_reg      <= 1'b1;
         oe_prev_reg   <= 1'b0;
         mode_reg      <= MODE_RESET_VAL;
         req_n_reg     <= 1'b1;
         od_pull_reg   <= 1'b0;
         od_level_reg  <= 1'b0;
      end else begin
         state_reg     <= state_next;
         addr_reg      <= addr_next;
         addr_done_reg <= addr_done_next;
         osc_reg       <= osc_next;
         sclk_reg      <= sclk_next;
         data_reg      <= data_next;
         data_oe_reg   <= data_oe_next;
         casc_reg      <= casc_next;
         oe_prev_reg   <= oe_s;
         mode_reg      <= mode_next;
         req_n_reg     <= req_n_next;
         od_pull_reg   <= od_pull_next;
         od_level_reg  <= od_level_next;
      end
   end

   // Outputs straight from flip-flops
   // only direct pins face the target
   assign serial_config_clock_o = sclk_reg;
   assign serial_data_o         = data_reg;
   assign serial_data_oe_o      = data_oe_reg;
   assign cascade_out_n_o       = casc_reg;
   assign mode_o                = mode_reg;
   assign reconfig_request_n_o  = req_n_reg;
   // open drain: only ever pull low, never drive high
   assign oe_reset_o            = od_level_reg;
   assign oe_reset_oe_o         = od_pull_reg;
endmodule : serial_config_image_streamer

//--- testbench/cfg_target_model.sv
// Target model: samples the serial image on each rising serial clock
`timescale 1ns/1ps
module cfg_target_model (
   // Clock and bench control
   input  wire logic ref_clk_i,
   input  wire logic clear_i,
   // Serial side
   input  wire logic sclk_i,
   input  wire logic data_i,
   input  wire logic data_oe_i,
   // Captured image
   output logic [15:0] bits_o,
   output logic [7:0]  count_o,
   output logic        float_o
);
   logic sclk_reg;  // Serial clock one cycle ago
   logic last_reg;  // Wire level one cycle ago
   logic line;      // Level on the data wire
   // Released wire shows the inverse level, so floating never looks valid
   assign line = data_oe_i ? data_i : ~last_reg;
   // only direct pins, one bit per rising edge
   always_ff @(posedge ref_clk_i) begin
      sclk_reg <= sclk_i;
      // Cleared with the record, so a floating wire starts from a known level
      last_reg <= clear_i ? 1'b0 : line;
      if (clear_i) begin
         count_o <= 8'h00;
         bits_o <= 16'h0000;
         float_o <= 1'b0;
      end else if (sclk_i && !sclk_reg) begin
         bits_o[count_o[3:0]] <= line;
         count_o <= count_o + 8'h01;
         // Sampling a floating line is a fault
         if (!data_oe_i) float_o <= 1'b1;
      end
   end
endmodule : cfg_target_model

//--- testbench/serial_config_image_streamer_chk.sv
// Checker: pin level properties of the image streamer
`timescale 1ns/1ps
module serial_config_image_streamer_chk
   import cfg_stream_pkg::*;
(
   // Clock, reset and pins
   input wire logic                              ref_clk_i,
   input wire logic                              rst_i,
   input wire logic                              chip_select_n_i,
   input wire logic                              oe_reset_i,
   input wire logic                              oe_reset_o,
   input wire logic                              oe_reset_oe_o,
   input wire logic [cfg_stream_pkg::MODE_W-1:0] mode_strap_i,
   input wire logic [cfg_stream_pkg::MODE_W-1:0] mode_o,
   input wire logic                              serial_config_clock_o,
   input wire logic                              serial_data_o,
   input wire logic                              serial_data_oe_o,
   input wire logic                              cascade_out_n_o,
   input wire logic                              scan_reconfig_i,
   input wire logic                              reconfig_request_n_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   AST_OE_LOW_FLOAT: assert property (!oe_reset_i [*4] |-> !serial_data_oe_o)
      else $error("data driven while reset line low");
   AST_CS_HIGH_FLOAT: assert property (chip_select_n_i [*4] |-> !serial_data_oe_o)
      else $error("data driven while deselected");
   AST_CLK_STOP: assert property ((chip_select_n_i || !oe_reset_i) [*4] |-> !serial_config_clock_o)
      else $error("serial clock runs while disabled");
   AST_MODE_CAPTURE: assert property ($rose(oe_reset_i) ##1 (oe_reset_i && $stable(mode_strap_i)) [*4]
      |-> mode_o == mode_strap_i) else $error("mode not captured");
   AST_CASC_FLOAT: assert property (!cascade_out_n_o && !$past(cascade_out_n_o) |-> !serial_data_oe_o)
      else $error("data driven after cascade");
   AST_OPEN_DRAIN: assert property (oe_reset_oe_o |-> !oe_reset_o)
      else $error("reset line driven high");
   AST_REQ_LOW: assert property (scan_reconfig_i [*4] |-> !reconfig_request_n_o)
      else $error("request not driven low");
   AST_REQ_HIGH: assert property (!scan_reconfig_i [*4] |-> reconfig_request_n_o)
      else $error("request not released");
   AST_DATA_HOLD: assert property (serial_data_oe_o && $past(serial_data_oe_o) && !$fell(serial_config_clock_o)
      |-> $stable(serial_data_o)) else $error("data changed off falling clock");
   AST_SCLK_HIGH: assert property (disable iff (rst_i || chip_select_n_i || !oe_reset_i)
      $rose(serial_config_clock_o) |-> serial_config_clock_o [*5] ##1 !serial_config_clock_o)
      else $error("serial clock high time wrong");
   // Main scenarios reached
   COV_START: cover property ($rose(serial_data_oe_o));
   COV_CASC: cover property ($fell(cascade_out_n_o));
   COV_REQ: cover property ($fell(reconfig_request_n_o));
endmodule : serial_config_image_streamer_chk
bind serial_config_image_streamer serial_config_image_streamer_chk chk_inst (.*);

//--- testbench/serial_config_image_streamer_tb.sv
// Testbench: streams a short image through the streamer into a target model
`timescale 1ns/1ps
module serial_config_image_streamer_tb;
   import cfg_stream_pkg::*;
   localparam int BITS = 16;                   // Short image keeps runs brief
   localparam logic [15:0] IMG = 16'ha5c3;     // Bit 0 leaves first
   logic ref_clk, rst, cs_n, pull, scan, clear, line, oe_o, oe_oe;
   logic sclk, sdata, sdata_oe, casc_n, req_n, float_hit;
   logic [MODE_W-1:0] strap, mode;
   logic [15:0] bits;
   logic [7:0] count;
   int err_count, total_checks, cycles;
   // pull-up line, low when either side pulls
   assign line = !(pull || (oe_oe && !oe_o));
   always #2 ref_clk = ~ref_clk;
   serial_config_image_streamer #(.IMAGE_BITS(BITS), .ADDR_W(4), .IMAGE_INIT(IMG))
   serial_config_image_streamer_inst (.ref_clk_i(ref_clk), .rst_i(rst), .chip_select_n_i(cs_n),
      .oe_reset_i(line), .oe_reset_o(oe_o), .oe_reset_oe_o(oe_oe), .mode_strap_i(strap),
      .mode_o(mode), .serial_config_clock_o(sclk), .serial_data_o(sdata),
      .serial_data_oe_o(sdata_oe), .cascade_out_n_o(casc_n), .scan_reconfig_i(scan),
      .reconfig_request_n_o(req_n));
   cfg_target_model cfg_target_model_inst (.ref_clk_i(ref_clk), .clear_i(clear), .sclk_i(sclk),
      .data_i(sdata), .data_oe_i(sdata_oe), .bits_o(bits), .count_o(count), .float_o(float_hit));
   logic casc_nc_n;                            // Cascade pin of the variant without cascading
   // variant built without cascading, fed the same pins
   serial_config_image_streamer #(.IMAGE_BITS(BITS), .ADDR_W(4), .IMAGE_INIT(IMG),
      .HAS_CASCADE(1'b0))
   serial_config_image_streamer_nc_inst (.ref_clk_i(ref_clk), .rst_i(rst), .chip_select_n_i(cs_n),
      .oe_reset_i(line), .oe_reset_o(), .oe_reset_oe_o(), .mode_strap_i(strap), .mode_o(),
      .serial_config_clock_o(), .serial_data_o(), .serial_data_oe_o(),
      .cascade_out_n_o(casc_nc_n), .scan_reconfig_i(scan), .reconfig_request_n_o());
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // Hang guard, far above five short streams and an abort
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   // Request line follows the scan level both ways
   task automatic t_scan();
      scan = 1'b1;
      tick(4);
      check(16'(req_n), 16'h0000);
      scan = 1'b0;
      tick(4);
      check(16'(req_n), 16'h0001);
   endtask : t_scan
   // Full stream after a reset pulse; also proves restart from bit 0
   task automatic t_stream(input logic [MODE_W-1:0] m);
      int n;
      pull = 1'b1;
      cs_n = 1'b1;
      strap = m;
      clear = 1'b1;
      tick(6);
      clear = 1'b0;
      pull = 1'b0;
      tick(8);
      check(16'(mode), 16'(m));
      check(16'({sclk, sdata_oe, line, oe_oe}), 16'h0002);
      check(16'({oe_oe, oe_o}), 16'h0000);
      cs_n = 1'b0;
      n = 0;
      while (casc_n !== 1'b0 && n < 1000) begin
         tick(1);
         n++;
      end
      tick(2);
      check(bits, IMG);
      check(16'(count), 16'(BITS));
      check(16'({float_hit, sdata_oe, sclk, casc_n}), 16'h0000);
      check(16'(casc_nc_n), 16'h0001);
   endtask : t_stream
   // Halt mid-stream, resume, then reset with select still low
   task automatic t_abort();
      pull = 1'b1;
      tick(6);
      pull = 1'b0;
      cs_n = 1'b0;
      tick(60);
      check(16'(sdata_oe), 16'h0001);
      cs_n = 1'b1;
      tick(4);
      check(16'({sdata_oe, sclk}), 16'h0000);
      cs_n = 1'b0;
      tick(30);
      pull = 1'b1;
      tick(4);
      check(16'({sdata_oe, sclk, casc_n}), 16'h0001);
   endtask : t_abort
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      cs_n = 1'b1;
      pull = 1'b1;
      scan = 1'b0;
      clear = 1'b1;
      strap = '0;
      err_count = 0;
      total_checks = 0;
      cycles = 0;
      tick(10);
      rst = 1'b0;
      t_scan();
      for (int i = 0; i < 4; i++) t_stream(MODE_W'(i));
      t_abort();
      t_stream(MODE_W'(1));
      print_verdict();
   end
endmodule : serial_config_image_streamer_tb
